// *** core/ltmc_lin_ctrl.sv ***
// LIN transceiver mode control: mode, enabling sequence, wake detect, receive path
`timescale 1ns/10ps
`include "ltmc_defs.svh"

// Overview of operation
// - Mode is off after reset until a mode command arrives.
// - Off mode accepted in every chip operating mode.
// - In off mode bus wake patterns are ignored entirely.
// - Normal mode granted only by command while chip is in normal mode.
// - Each transceiver's mode comes from its own mode field write.
// - Transmit input low at enable end is held off until it returns high.
// - In normal mode, once the enabling sequence has run, bus driver follows transmit input.
// - Receive output shows filtered bus level in normal and receive-only modes, low means dominant; other modes hold it high, wake mode only until a wake.
// - Wake-capable mode monitors bus for wake events.
// - Receive-only mode disables driver, keeps reception; normal or stop only.
// - Field value 01 selects wake mode; reads 01 after wake until another mode.
// - Wake: fall, dominant beyond wake time, rise; receive output then held low.
module ltmc_lin_ctrl
    import ltmc_pkg::*;
#(
    parameter int EN_CYCLES   = `LTMC_EN_CYCLES,
    parameter int WAKE_CYCLES = `LTMC_WAKE_CYCLES,
    parameter int FILT_CYCLES = `LTMC_FILT_CYCLES
)
(
    input  wire logic       clock,              // 200 MHz clock
    input  wire logic       reset,              // Synchronous reset, high
    input  wire logic       mode_wr,            // Mode field write strobe
    input  wire logic [1:0] mode_wdata,         // Requested mode field
    input  wire logic [2:0] chip_mode,          // Chip operating mode
    input  wire logic       bus_transmit_input, // Transmit pin from processor
    input  wire logic       bus_level,          // Bus comparator, low dominant
    input  wire logic       rx_ready,           // Receiver side may take a level
    output logic [1:0]      mode_field,         // Mode field readback
    output logic            bus_drive_dom,      // Driver pulls bus dominant
    output logic            bus_receive_output, // Receive pin to processor
    output logic            wake_event,         // One-cycle wake pulse
    output logic            rx_stall            // Receive buffer full
);
    localparam int FW = $clog2(FILT_CYCLES + 1);
    localparam int EW = $clog2(EN_CYCLES + 1);
    localparam int WW = $clog2(WAKE_CYCLES + 1);

    ltmc_rx_if rxq();

    logic       txd_s1_ff, txd_s2_ff, bus_s1_ff, bus_s2_ff;
    logic [1:0] mode_ff;
    ltmc_en_e   en_ff;
    ltmc_wk_e   wk_ff;
    logic [EW-1:0] en_cnt_ff;
    logic [WW-1:0] wk_cnt_ff;
    logic [FW-1:0] filt_cnt_ff;
    logic       filt_ff, filt_cand_ff, drive_ff, rxo_ff, wake_ff, stall_ff, filt_d_ff, sent_ff;
    logic       grant, filt_new, buf_in_ready, txd_eff;

    // Pins cross in from outside: two stages before use
    always_ff @(posedge clock)
    begin
        txd_s1_ff <= bus_transmit_input;
        txd_s2_ff <= txd_s1_ff;
        bus_s1_ff <= bus_level;
        bus_s2_ff <= bus_s1_ff;
    end

    function automatic logic mode_allowed(input logic [1:0] m, input logic [2:0] cm);
        case (m)
            `LTMC_MODE_OFF:    mode_allowed = 1'b1;
            `LTMC_MODE_NORMAL: mode_allowed = (cm == `LTMC_CHIP_NORMAL);
            `LTMC_MODE_RXONLY: mode_allowed = (cm == `LTMC_CHIP_NORMAL) ||
                                              (cm == `LTMC_CHIP_STOP);
            default:           mode_allowed = (cm != `LTMC_CHIP_FAILSAFE);
        endcase
    endfunction

    assign grant = mode_wr && mode_allowed(mode_wdata, chip_mode);

    // Refused writes leave the mode untouched
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            mode_ff <= `LTMC_MODE_OFF;
        end
        else if (grant)
        begin
            mode_ff <= mode_wdata;
        end
    end

    // Enabling sequence; a low input at the end must first go high
    always_ff @(posedge clock)
    begin
        if (reset || (grant && mode_wdata != `LTMC_MODE_NORMAL) || mode_ff != `LTMC_MODE_NORMAL)
        begin
            en_ff     <= LTMC_EN_IDLE;
            en_cnt_ff <= '0;
            if (!reset && grant && mode_wdata == `LTMC_MODE_NORMAL && mode_ff != `LTMC_MODE_NORMAL)
            begin
                en_ff <= LTMC_EN_WAIT;
            end
        end
        else
        begin
            case (en_ff)
                LTMC_EN_WAIT:
                begin
                    if (en_cnt_ff == EW'(EN_CYCLES - 1))
                    begin
                        en_ff <= txd_s2_ff ? LTMC_EN_RUN : LTMC_EN_HOLD;
                    end
                    else
                    begin
                        en_cnt_ff <= en_cnt_ff + 1'b1;
                    end
                end
                LTMC_EN_HOLD:
                begin
                    if (txd_s2_ff)
                    begin
                        en_ff <= LTMC_EN_RUN;
                    end
                end
                default: en_ff <= en_ff;
            endcase
        end
    end

    assign txd_eff = (mode_ff == `LTMC_MODE_NORMAL && en_ff == LTMC_EN_RUN) ? txd_s2_ff : 1'b1;

    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            drive_ff <= 1'b0;
        end
        else
        begin
            drive_ff <= !txd_eff;
        end
    end

    // Glitch filter: level accepted after a steady run
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            filt_ff      <= 1'b1;
            filt_cand_ff <= 1'b1;
            filt_cnt_ff  <= '0;
        end
        else if (bus_s2_ff != filt_cand_ff)
        begin
            filt_cand_ff <= bus_s2_ff;
            filt_cnt_ff  <= '0;
        end
        else if (filt_cnt_ff == FW'(FILT_CYCLES - 1))
        begin
            filt_ff <= filt_cand_ff;
        end
        else
        begin
            filt_cnt_ff <= filt_cnt_ff + 1'b1;
        end
    end

    // Offer stays up until taken, so the latest level always gets through
    assign filt_new = (filt_ff != sent_ff);

    // Last filtered level and last level queued
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            filt_d_ff <= 1'b1;
            sent_ff   <= 1'b1;
        end
        else
        begin
            filt_d_ff <= filt_ff;
            if (filt_new && buf_in_ready)
            begin
                sent_ff <= filt_ff;
            end
        end
    end

    // A long stall skips middle edges but never the final level
    ltmc_rx_buf #(.WIDTH(1), .DEPTH(2)) u_buf (
        .clock    (clock),
        .reset    (reset),
        .in_valid (filt_new),
        .in_data  (filt_ff),
        .in_ready (buf_in_ready),
        .out      (rxq.src)
    );
    assign rxq.ready = rx_ready;

    // Wake detect; only leaving wake mode rearms it, a rewrite of 01 does not
    always_ff @(posedge clock)
    begin
        if (reset || mode_ff != `LTMC_MODE_WAKE || (grant && mode_wdata != `LTMC_MODE_WAKE))
        begin
            wk_ff     <= LTMC_WK_IDLE;
            wk_cnt_ff <= '0;
        end
        else
        begin
            case (wk_ff)
                LTMC_WK_IDLE:
                begin
                    if (!filt_ff && filt_d_ff)
                    begin
                        wk_ff     <= LTMC_WK_DOM;
                        wk_cnt_ff <= '0;
                    end
                end
                LTMC_WK_DOM:
                begin
                    if (filt_ff)
                    begin
                        wk_ff <= LTMC_WK_IDLE;
                    end
                    else if (wk_cnt_ff == WW'(WAKE_CYCLES))
                    begin
                        wk_ff <= LTMC_WK_LONG;
                    end
                    else
                    begin
                        wk_cnt_ff <= wk_cnt_ff + 1'b1;
                    end
                end
                LTMC_WK_LONG:
                begin
                    if (filt_ff)
                    begin
                        wk_ff <= LTMC_WK_DONE;
                    end
                end
                default: wk_ff <= wk_ff;
            endcase
        end
    end

    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            wake_ff  <= 1'b0;
            rxo_ff   <= 1'b1;
            stall_ff <= 1'b0;
        end
        else
        begin
            wake_ff  <= (wk_ff == LTMC_WK_LONG) && filt_ff && (mode_ff == `LTMC_MODE_WAKE) &&
                        !(grant && mode_wdata != `LTMC_MODE_WAKE);
            stall_ff <= !buf_in_ready;
            if (mode_ff == `LTMC_MODE_WAKE && wk_ff == LTMC_WK_DONE)
            begin
                rxo_ff <= 1'b0;
            end
            else if (mode_ff == `LTMC_MODE_NORMAL || mode_ff == `LTMC_MODE_RXONLY)
            begin
                if (rxq.valid && rx_ready)
                begin
                    rxo_ff <= rxq.level;
                end
                else if (!rxq.valid && !filt_new)
                begin
                    rxo_ff <= filt_ff;
                end
            end
            else
            begin
                rxo_ff <= 1'b1;
            end
        end
    end

    assign mode_field         = mode_ff;
    assign bus_drive_dom      = drive_ff;
    assign bus_receive_output = rxo_ff;
    assign wake_event         = wake_ff;
    assign rx_stall           = stall_ff;
endmodule // ltmc_lin_ctrl

// *** pkg/ltmc_defs.svh ***
// Constants of the LIN transceiver mode control block
`ifndef LTMC_DEFS_SVH
`define LTMC_DEFS_SVH
`define LTMC_MODE_OFF       2'h0
`define LTMC_MODE_WAKE      2'h1
`define LTMC_MODE_RXONLY    2'h2
`define LTMC_MODE_NORMAL    2'h3
`define LTMC_CHIP_NORMAL    3'h0
`define LTMC_CHIP_STOP      3'h1
`define LTMC_CHIP_SLEEP     3'h2
`define LTMC_CHIP_RESTART   3'h3
`define LTMC_CHIP_FAILSAFE  3'h4
`define LTMC_CLK_MHZ        200
`define LTMC_EN_TIME_NS     10000
`define LTMC_EN_CYCLES      ((`LTMC_EN_TIME_NS * `LTMC_CLK_MHZ + 999) / 1000)
`define LTMC_WAKE_TIME_NS   30000
`define LTMC_WAKE_CYCLES    ((`LTMC_WAKE_TIME_NS * `LTMC_CLK_MHZ + 999) / 1000)
`define LTMC_FILT_CYCLES    4
`endif

// *** pkg/ltmc_pkg.sv ***
// Types of the LIN transceiver mode control block
package ltmc_pkg;
    typedef enum logic [1:0] {LTMC_OFF, LTMC_WAKE, LTMC_RXONLY, LTMC_NORMAL} ltmc_mode_e;
    typedef enum logic [1:0] {LTMC_EN_IDLE, LTMC_EN_WAIT, LTMC_EN_HOLD, LTMC_EN_RUN} ltmc_en_e;
    typedef enum logic [1:0] {LTMC_WK_IDLE, LTMC_WK_DOM, LTMC_WK_LONG, LTMC_WK_DONE} ltmc_wk_e;
endpackage

// *** pkg/ltmc_rx_if.sv ***
// Receive path handshake between buffer and transceiver core
`timescale 1ns/10ps
interface ltmc_rx_if;
    logic valid;
    logic ready;
    logic level;
    modport src (output valid, output level, input ready);
    modport dst (input valid, input level, output ready);
endinterface

// *** core/ltmc_rx_buf.sv ***
// Two-entry buffer carrying filtered bus levels
`timescale 1ns/10ps
module ltmc_rx_buf
#(
    parameter int WIDTH = 1,
    parameter int DEPTH = 2
)
(
    input  wire logic             clock,    // System clock
    input  wire logic             reset,    // Synchronous reset
    input  wire logic             in_valid, // Word offered
    input  wire logic [WIDTH-1:0] in_data,  // Word
    output logic                  in_ready, // Room left
    ltmc_rx_if.src                out       // Drain side
);
    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [$clog2(DEPTH):0] cnt_ff;
    logic [$clog2(DEPTH)-1:0] wp_ff, rp_ff;
    logic wr, rd;

    assign in_ready  = (cnt_ff != DEPTH[$clog2(DEPTH):0]);
    assign out.valid = (cnt_ff != '0);
    assign out.level = mem_ff[rp_ff][0];
    assign wr = in_valid && in_ready;
    assign rd = out.valid && out.ready;

    always_ff @(posedge clock)
    begin
        if (wr)
        begin
            mem_ff[wp_ff] <= in_data;
        end
    end

    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            cnt_ff <= '0;
            wp_ff  <= '0;
            rp_ff  <= '0;
        end
        else
        begin
            cnt_ff <= cnt_ff + {{$clog2(DEPTH){1'b0}}, wr} - {{$clog2(DEPTH){1'b0}}, rd};
            if (wr)
            begin
                wp_ff <= (wp_ff == ($clog2(DEPTH))'(DEPTH - 1)) ? '0 : wp_ff + 1'b1;
            end
            if (rd)
            begin
                rp_ff <= (rp_ff == ($clog2(DEPTH))'(DEPTH - 1)) ? '0 : rp_ff + 1'b1;
            end
        end
    end
endmodule // ltmc_rx_buf

// *** sim/ltmc_bus_node.sv ***
// Bus wire and receiving processor pin model
`timescale 1ns/10ps
module ltmc_bus_node
(
    input  wire logic bus_drive_dom, // Transceiver pulls low
    input  wire logic remote_dom,    // Other node pulls low
    input  wire logic hold,          // Processor stalls reception
    output logic      bus_level,     // Wire with pull-up
    output logic      rx_ready       // Processor takes levels
);
    // Wired-AND: a released wire rises through the pull-up
    assign bus_level = ~(bus_drive_dom | remote_dom);
    assign rx_ready  = ~hold;
endmodule // ltmc_bus_node

// *** sim/ltmc_lin_ctrl_monitor.sv ***
// Assertions on the LIN mode control ports
`timescale 1ns/10ps
module ltmc_lin_ctrl_monitor
#(
    parameter int EN_CYCLES = 8
)
(
    input wire logic       clock,              // Clock
    input wire logic       reset,              // Sync reset
    input wire logic       mode_wr,            // Write strobe
    input wire logic [1:0] mode_wdata,         // Requested mode
    input wire logic [2:0] chip_mode,          // Chip mode
    input wire logic       bus_transmit_input, // Transmit pin
    input wire logic [1:0] mode_field,         // Mode readback
    input wire logic       bus_drive_dom,      // Driver on
    input wire logic       bus_receive_output, // Receive pin
    input wire logic       wake_event          // Wake pulse
);
    logic [15:0] en_cnt_ff;
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    sequence s_norm_req;
        mode_wr && mode_wdata == 2'h3 && chip_mode == 3'h0;
    endsequence
    sequence s_woken;
        wake_event && !mode_wr ##1 (!mode_wr) [*4];
    endsequence
    // Saturates so a long normal stay never wraps
    always_ff @(posedge clock)
    begin
        if (reset)
            en_cnt_ff <= 16'hFFFF;
        else if (mode_wr && mode_wdata == 2'h3 && chip_mode == 3'h0 && mode_field != 2'h3)
            en_cnt_ff <= 16'h0000;
        else if (en_cnt_ff != 16'hFFFF)
            en_cnt_ff <= en_cnt_ff + 16'h0001;
    end
    a_reset_off_idle: assert property ($fell(reset) |-> mode_field == 2'h0 && !bus_drive_dom
        && bus_receive_output)
        else $error("outputs not idle after reset");
    a_off_always: assert property (mode_wr && mode_wdata == 2'h0 |=> mode_field == 2'h0)
        else $error("off mode refused");
    a_normal_grant: assert property (s_norm_req |=> mode_field == 2'h3)
        else $error("normal mode not granted");
    a_mode_held: assert property (!mode_wr |=> $stable(mode_field))
        else $error("mode changed without write");
    a_quiet_enable: assert property (mode_field == 2'h3 && en_cnt_ff < EN_CYCLES
        |-> !bus_drive_dom)
        else $error("driver on within enabling time");
    a_other_no_drive: assert property (mode_field != 2'h3 && $past(mode_field) != 2'h3 |-> !bus_drive_dom)
        else $error("driver on outside normal mode");
    a_drive_cause: assert property (bus_drive_dom |-> $past(bus_transmit_input, 3) == 1'h0)
        else $error("driver on without low transmit input");
    a_off_no_wake: assert property (mode_field == 2'h0 |=> !wake_event)
        else $error("wake raised in off mode");
    a_wake_rx_low: assert property (s_woken |-> !bus_receive_output)
        else $error("receive pin released after wake");
endmodule // ltmc_lin_ctrl_monitor

// *** sim/test_lin_transceiver_mode_control.sv ***
// Self-checking bench for the LIN mode control block
`timescale 1ns/10ps
module test_lin_transceiver_mode_control;
    import ltmc_pkg::*;
    logic       clock      = 1'h0;
    logic       reset      = 1'h1;
    logic       mode_wr    = 1'h0;
    logic [1:0] mode_wdata = 2'h0;
    logic [2:0] chip_mode  = 3'h0;
    logic       txd        = 1'h1;
    logic       remote_dom = 1'h0;
    logic       hold       = 1'h0;
    logic       bus_level, rx_ready, bus_drive_dom, rx_out, wake_event, rx_stall;
    logic [1:0] mode_field;
    int         miscompares = 0;
    int         compares    = 0;
    ltmc_lin_ctrl #(.EN_CYCLES(8), .WAKE_CYCLES(16), .FILT_CYCLES(2)) ltmc_lin_ctrl_i (
        .clock(clock), .reset(reset), .mode_wr(mode_wr), .mode_wdata(mode_wdata), .chip_mode(chip_mode),
        .bus_transmit_input(txd), .bus_level(bus_level), .rx_ready(rx_ready), .mode_field(mode_field),
        .bus_drive_dom(bus_drive_dom), .bus_receive_output(rx_out), .wake_event(wake_event), .rx_stall(rx_stall));
    ltmc_bus_node ltmc_bus_node_i (.bus_drive_dom(bus_drive_dom), .remote_dom(remote_dom), .hold(hold),
        .bus_level(bus_level), .rx_ready(rx_ready));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic wr(input logic [1:0] m, input logic [2:0] c);
        chip_mode  = c;
        mode_wdata = m;
        mode_wr    = 1'h1;
        step(1);
        mode_wr = 1'h0;
        step(1);
    endtask
    // Remote node holds the wire low, then frees it; wake pulses counted
    task automatic pulse(input int low, output int n);
        n = 0;
        for (int i = 0; i < low + 20; i++)
        begin
            remote_dom = (i < low);
            step(1);
            if (wake_event !== 1'h0)
                n += (wake_event === 1'h1) ? 1 : 16;
        end
    endtask
    task automatic t_modes;
        logic ok;
        for (int c = 0; c < 5; c++)
            for (int m = 1; m < 4; m++)
            begin
                ok = (m == 3) ? (c == 0) : (m == 2) ? (c < 2) : (c != 4);
                wr(m[1:0], c[2:0]);
                chk({6'h00, mode_field}, ok ? m[7:0] : 8'h00);
                wr(2'h0, c[2:0]);
                chk({6'h00, mode_field}, 8'h00);
            end
    endtask
    task automatic t_enable;
        wr(2'h3, 3'h0);
        step(12);
        txd = 1'h0;
        step(4);
        chk({7'h00, bus_drive_dom}, 8'h01);
        step(10);
        chk({7'h00, rx_out}, 8'h00);
        wr(2'h0, 3'h0);
        wr(2'h3, 3'h0);
        step(20);
        chk({7'h00, bus_drive_dom}, 8'h00);
        txd = 1'h1;
        step(4);
        txd = 1'h0;
        step(4);
        chk({7'h00, bus_drive_dom}, 8'h01);
        txd = 1'h1;
        step(14);
        chk({6'h00, bus_drive_dom, rx_out}, 8'h01);
        wr(2'h0, 3'h0);
    endtask
    // Reader stalls while levels keep arriving, then drains
    task automatic t_rxonly;
        wr(2'h2, 3'h1);
        txd  = 1'h0;
        hold = 1'h1;
        for (int i = 0; i < 5; i++)
        begin
            remote_dom = ~remote_dom;
            step(8);
        end
        chk({6'h00, bus_drive_dom, rx_stall}, 8'h01);
        hold = 1'h0;
        step(20);
        chk({6'h00, rx_stall, rx_out}, 8'h00);
        remote_dom = 1'h0;
        txd        = 1'h1;
        wr(2'h0, 3'h0);
    endtask
    task automatic t_wake;
        int n;
        pulse(60, n);
        chk({n[6:0], rx_out}, 8'h01);
        wr(2'h1, 3'h1);
        pulse(10, n);
        chk({n[6:0], rx_out}, 8'h01);
        pulse(40, n);
        chk({n[4:0], rx_out, mode_field}, 8'h09);
        wr(2'h1, 3'h1);
        step(4);
        chk({5'h00, rx_out, mode_field}, 8'h01);
        wr(2'h2, 3'h1);
        step(2);
        chk({7'h00, rx_out}, 8'h01);
        wr(2'h1, 3'h1);
        chk({5'h00, rx_out, mode_field}, 8'h05);
    endtask
    task automatic end_of_test;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial
    begin
        forever #2.5 clock = ~clock;
    end
    // Whole run is about four hundred cycles; thirty thousand means a hang
    initial
    begin
        #150000;
        miscompares++;
        end_of_test;
    end
    initial
    begin
        step(20);
        reset = 1'h0;
        step(1);
        chk({4'h0, mode_field, bus_drive_dom, rx_out}, 8'h01);
        t_modes;
        t_enable;
        t_rxonly;
        t_wake;
        end_of_test;
    end
endmodule // test_lin_transceiver_mode_control
bind ltmc_lin_ctrl ltmc_lin_ctrl_monitor #(.EN_CYCLES(EN_CYCLES)) ltmc_lin_ctrl_monitor_i (.clock(clock),
    .reset(reset), .mode_wr(mode_wr), .mode_wdata(mode_wdata), .chip_mode(chip_mode),
    .bus_transmit_input(bus_transmit_input), .mode_field(mode_field), .bus_drive_dom(bus_drive_dom),
    .bus_receive_output(bus_receive_output), .wake_event(wake_event));
